// File: conn_cfg_pkg.sv
/*
  Shared constants for the connection identifier and size configuration block:
  register offsets, control and status bit positions, selector codes, identifier
  values and pool sizes, size limits and the configuration state type.
  Assumes a single 250 MHz clock domain and a 32-bit register port.
*/
`default_nettype none
package conn_cfg_pkg;
  // Register offsets, one 32-bit word each.
  localparam logic [7:0] CTRL_OFS   = 8'h00;
  localparam logic [7:0] NODE_OFS   = 8'h04;
  localparam logic [7:0] TXLIM_OFS  = 8'h08;
  localparam logic [7:0] RXLIM_OFS  = 8'h0C;
  localparam logic [7:0] TXID_OFS   = 8'h10;
  localparam logic [7:0] RXID_OFS   = 8'h14;
  localparam logic [7:0] POOL_OFS   = 8'h18;
  localparam logic [7:0] STAT_OFS   = 8'h1C;
  localparam logic [7:0] MASK_OFS   = 8'h20;
  localparam logic [7:0] SIZE_OFS   = 8'h24;
  // Control register bit positions.
  localparam int CTRL_EXPL_BIT  = 0;
  localparam int CTRL_FTX_BIT   = 1;
  localparam int CTRL_FRX_BIT   = 2;
  localparam int CTRL_TXNL_BIT  = 3;
  localparam int CTRL_RXNL_BIT  = 4;
  localparam int CTRL_APPLY_BIT = 5;
  localparam int CTRL_SEL_LSB   = 8;
  // Selector nibble codes.
  localparam logic [3:0] SEL_G1      = 4'h0;
  localparam logic [3:0] SEL_G2_DST  = 4'h1;
  localparam logic [3:0] SEL_G2_SRC  = 4'h2;
  localparam logic [3:0] SEL_G3      = 4'h3;
  localparam logic [3:0] SEL_RSV_LO  = 4'h4;
  localparam logic [3:0] SEL_DEFAULT = 4'hF;
  localparam logic [7:0] SEL_EXPLICIT = 8'h33;
  localparam logic [7:0] SEL_RESET    = 8'hFF;
  // Identifier values and pool sizes.
  localparam logic [15:0] ID_DEFAULT = 16'hFFFF;
  localparam logic [15:0] ID_MAX     = 16'h07F0;
  localparam int G1_POOL = 16;
  localparam int G2_POOL = 8;
  localparam int G3_POOL = 7;
  // Size limits.
  localparam logic [11:0] SIZE_RESET   = 12'h000;
  localparam logic [11:0] SIZE_NOFRAG  = 12'h007;
  localparam logic [11:0] SIZE_SINGLE  = 12'h008;
  localparam logic [11:0] SIZE_NOLIMIT = 12'hFFF;
  // Status bit positions.
  localparam int ST_DONE     = 0;
  localparam int ST_INVALID  = 1;
  localparam int ST_POOL     = 2;
  localparam int ST_DISCARD  = 3;
  localparam int ST_NODATA   = 4;
  localparam int ST_OVERSIZE = 5;
  localparam int ST_W        = 6;
  localparam int SIZE_FRAG_BIT = 16;
  typedef enum logic [1:0] {CFG_IDLE, CFG_TX, CFG_RX} cfg_state_type;
endpackage
`default_nettype wire

// File: connection_id_and_size_config.sv
/*
  Connection identifier and size configuration for one fieldbus endpoint.
  Decodes the message-group selector, allocates message IDs from three pools,
  holds the transmit and receive identifiers and size limits, screens outgoing
  and incoming messages and raises events through a masked interrupt.
  Assumes the message ports come from logic on mclk and the register master
  follows the one-cycle strobe protocol.
*/
// Our own choices: the plain strobed port and the address map.
`timescale 1ns/100ps
`default_nettype none
module connection_id_and_size_config
  import conn_cfg_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        rst_n,
  input  wire logic [7:0]  regAddr,
  input  wire logic [31:0] regWdata,
  input  wire logic        regWr,
  input  wire logic        regRd,
  output logic      [31:0] regRdata,
  output logic             irq,
  input  wire logic        txReq,
  input  wire logic [11:0] txLen,
  output logic             txGrant,
  output logic             txBlock,
  output logic             txFragment,
  output logic      [15:0] txIdentifier,
  input  wire logic        rxMsgValid,
  input  wire logic [10:0] rxMsgId,
  input  wire logic [11:0] rxMsgLen,
  output logic             rxAccept,
  output logic             rxDiscard,
  output logic             rxNoData
);

  ////////////////////////////////////////////////////////////////////////////
  // State.
  cfg_state_type     stateReg, stateNext;
  logic [7:0]        selReg, selNext;
  logic [4:0]        ctrlReg, ctrlNext;
  logic [5:0]        nodeReg, nodeNext;
  logic [11:0]       txLimCfgReg, txLimCfgNext;
  logic [11:0]       rxLimCfgReg, rxLimCfgNext;
  logic [15:0]       txIdReg, txIdNext;
  logic [15:0]       rxIdReg, rxIdNext;
  logic [G1_POOL-1:0] g1UsedReg, g1UsedNext;
  logic [G2_POOL-1:0] g2UsedReg, g2UsedNext;
  logic [G3_POOL-1:0] g3UsedReg, g3UsedNext;
  logic [ST_W-1:0]   statusReg, statusNext;
  logic [ST_W-1:0]   maskReg, maskNext;
  logic [31:0]       rdataReg, readMux;
  logic              rxAcceptReg, rxDiscardReg, rxNoDataReg;
  logic [ST_W-1:0]   eventSet;

  // Returns {found, index} of the lowest clear bit among the first n bits.
  function automatic logic [4:0] lowestFree(input logic [15:0] used, input int n);
    logic [4:0] r;
    r = 5'h00;
    for (int i = n - 1; i >= 0; i--) begin
      if (!used[i]) begin
        r = {1'b1, 4'(i)};
      end
    end
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Decoding of the register port and the selector.
  wire        explicitMode = ctrlReg[CTRL_EXPL_BIT];
  wire        fragTxOk     = ctrlReg[CTRL_FTX_BIT];
  wire        fragRxOk     = ctrlReg[CTRL_FRX_BIT];
  wire        txNoLimit    = ctrlReg[CTRL_TXNL_BIT];
  wire        rxNoLimit    = ctrlReg[CTRL_RXNL_BIT];
  wire        wrCtrl       = regWr && (regAddr == CTRL_OFS);
  wire        applyReq     = wrCtrl && regWdata[CTRL_APPLY_BIT] && (stateReg == CFG_IDLE);
  wire        applyExpl    = regWdata[CTRL_EXPL_BIT];
  wire [7:0]  applySel     = applyExpl ? SEL_EXPLICIT : regWdata[CTRL_SEL_LSB +: 8];
  wire [3:0]  prodNib      = selReg[7:4];
  wire [3:0]  consNib      = selReg[3:0];
  wire        prodRsv      = (applySel[7:4] >= SEL_RSV_LO) && (applySel[7:4] != SEL_DEFAULT);
  wire        consRsv      = (applySel[3:0] >= SEL_RSV_LO) && (applySel[3:0] != SEL_DEFAULT);
  wire        applyBad     = applyReq && (prodRsv || consRsv);
  wire        applyGood    = applyReq && !(prodRsv || consRsv);
  wire        statRead     = regRd && (regAddr == STAT_OFS);
  // Software may load only a valid identifier or the default into the transmit register.
  wire        txIdWrOk     = (regWdata[15:0] <= ID_MAX) || (regWdata[15:0] == ID_DEFAULT);

  // Lowest free entry of each pool and the identifiers built from them.
  wire [4:0]  g1Free = lowestFree(16'(g1UsedReg), G1_POOL);
  wire [4:0]  g2Free = lowestFree(16'(g2UsedReg), G2_POOL);
  wire [4:0]  g3Free = lowestFree(16'(g3UsedReg), G3_POOL);
  wire [15:0] g1Id   = {6'h00, g1Free[3:0], nodeReg};
  wire [15:0] g2SrcId = {5'h00, 2'b10, nodeReg, g2Free[2:0]};
  wire [15:0] g3Id   = {5'h00, 2'b11, g3Free[2:0], nodeReg};

  // Effective size limits for explicit and I/O connections.
  wire [11:0] txLimEff = !explicitMode ? txLimCfgReg :
                         !fragTxOk ? SIZE_NOFRAG : txNoLimit ? SIZE_NOLIMIT : txLimCfgReg;
  wire [11:0] rxLimEff = !explicitMode ? rxLimCfgReg :
                         !fragRxOk ? SIZE_NOFRAG : rxNoLimit ? SIZE_NOLIMIT : rxLimCfgReg;
  wire        ioFrag   = !explicitMode && (txLimCfgReg > SIZE_SINGLE);

  ////////////////////////////////////////////////////////////////////////////
  // Message screening; transmit handshake outputs are combinational, receive verdicts are registered.
  wire txProducing = (txIdReg != ID_DEFAULT);
  wire txTooLong   = txLen > txLimEff;
  assign txGrant    = txReq && txProducing && !txTooLong;
  assign txBlock    = txReq && !txGrant;
  assign txFragment = explicitMode ? (txLen > SIZE_NOFRAG) : ioFrag;
  wire rxMatch   = rxMsgValid && (rxIdReg != ID_DEFAULT) && (rxMsgId == rxIdReg[10:0]);
  wire rxTooLong = rxMatch && (rxMsgLen > rxLimEff);
  wire rxEmpty   = rxMatch && !rxTooLong && !explicitMode &&
                   (rxMsgLen == 12'h000) && (rxLimEff != SIZE_RESET);

  // Events collected for the sticky status.
  always_comb begin
    eventSet              = '0;
    eventSet[ST_DONE]     = (stateReg == CFG_RX);
    eventSet[ST_INVALID]  = applyBad;
    eventSet[ST_POOL]     = (stateReg == CFG_TX) &&
                            (((prodNib == SEL_G1) && !g1Free[4]) ||
                             ((prodNib == SEL_G2_SRC) && !g2Free[4]) ||
                             ((prodNib == SEL_G3) && !g3Free[4])) ||
                            (stateReg == CFG_RX) && (consNib == SEL_G2_DST) && !g2Free[4];
    eventSet[ST_DISCARD]  = rxTooLong;
    eventSet[ST_NODATA]   = rxEmpty;
    eventSet[ST_OVERSIZE] = txReq && txTooLong;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic for configuration, allocation and registers.
  always_comb begin
    stateNext    = stateReg;
    selNext      = selReg;
    ctrlNext     = ctrlReg;
    nodeNext     = nodeReg;
    txLimCfgNext = txLimCfgReg;
    rxLimCfgNext = rxLimCfgReg;
    txIdNext     = txIdReg;
    rxIdNext     = rxIdReg;
    g1UsedNext   = g1UsedReg;
    g2UsedNext   = g2UsedReg;
    g3UsedNext   = g3UsedReg;
    maskNext     = maskReg;
    // Software writes; pool bits are released by writing ones.
    if (regWr) begin
      case (regAddr)
        CTRL_OFS:  ctrlNext = regWdata[4:0];
        NODE_OFS:  nodeNext = regWdata[5:0];
        TXLIM_OFS: txLimCfgNext = regWdata[11:0];
        RXLIM_OFS: rxLimCfgNext = regWdata[11:0];
        TXID_OFS: begin
          if (txIdWrOk) begin
            txIdNext = regWdata[15:0];
          end
        end
        RXID_OFS:  rxIdNext = regWdata[15:0];
        POOL_OFS: begin
          g1UsedNext = g1UsedReg & ~regWdata[15:0];
          g2UsedNext = g2UsedReg & ~regWdata[23:16];
          g3UsedNext = g3UsedReg & ~regWdata[30:24];
        end
        MASK_OFS:  maskNext = regWdata[ST_W-1:0];
        default: ;
      endcase
    end
    case (stateReg)
      CFG_IDLE: begin
        if (applyGood) begin
          selNext   = applySel;
          stateNext = CFG_TX;
          if (applySel[7:4] == SEL_DEFAULT) begin
            txIdNext = ID_DEFAULT;
          end
          if (applySel[3:0] == SEL_DEFAULT) begin
            rxIdNext = ID_DEFAULT;
          end
        end
      end
      CFG_TX: begin
        stateNext = CFG_RX;
        // The own node address in every built identifier keeps it unique.
        case (prodNib)
          SEL_G1: if (g1Free[4] && g1Id <= ID_MAX) begin
            txIdNext = g1Id;
            g1UsedNext[g1Free[3:0]] = 1'b1;
          end
          SEL_G2_SRC: if (g2Free[4] && g2SrcId <= ID_MAX) begin
            txIdNext = g2SrcId;
            g2UsedNext[g2Free[2:0]] = 1'b1;
          end
          SEL_G3: if (g3Free[4] && g3Id <= ID_MAX) begin
            txIdNext = g3Id;
            g3UsedNext[g3Free[2:0]] = 1'b1;
          end
          default: ;
        endcase
      end
      CFG_RX: begin
        stateNext = CFG_IDLE;
        if ((consNib == SEL_G2_DST) && g2Free[4] && g2SrcId <= ID_MAX) begin
          rxIdNext = g2SrcId;
          g2UsedNext[g2Free[2:0]] = 1'b1;
        end
      end
      default: stateNext = CFG_IDLE;
    endcase
  end

  // Sticky status: a read clears it, an event in the same cycle survives.
  assign statusNext = (statRead ? '0 : statusReg) | eventSet;

  // Read multiplexer; unmapped addresses read as zero.
  always_comb begin
    case (regAddr)
      CTRL_OFS:  readMux = {16'h0000, selReg, 3'b000, ctrlReg};
      NODE_OFS:  readMux = {26'h0, nodeReg};
      TXLIM_OFS: readMux = {20'h0, txLimCfgReg};
      RXLIM_OFS: readMux = {20'h0, rxLimCfgReg};
      TXID_OFS:  readMux = {16'h0000, txIdReg};
      RXID_OFS:  readMux = {16'h0000, rxIdReg};
      POOL_OFS:  readMux = {1'b0, g3UsedReg, g2UsedReg, g1UsedReg};
      STAT_OFS:  readMux = {26'h0, statusReg};
      MASK_OFS:  readMux = {26'h0, maskReg};
      SIZE_OFS:  readMux = {15'h0, ioFrag, 4'h0, txLimEff};
      default:   readMux = 32'h0000_0000;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Flip-flops.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      stateReg    <= CFG_IDLE;
      selReg      <= SEL_RESET;
      ctrlReg     <= '0;
      nodeReg     <= '0;
      txLimCfgReg <= SIZE_RESET;
      rxLimCfgReg <= SIZE_RESET;
      txIdReg     <= ID_DEFAULT;
      rxIdReg     <= ID_DEFAULT;
      g1UsedReg   <= '0;
      g2UsedReg   <= '0;
      g3UsedReg   <= '0;
      statusReg   <= '0;
      maskReg     <= '0;
    end else begin
      stateReg    <= stateNext;
      selReg      <= selNext;
      ctrlReg     <= ctrlNext;
      nodeReg     <= nodeNext;
      txLimCfgReg <= txLimCfgNext;
      rxLimCfgReg <= rxLimCfgNext;
      txIdReg     <= txIdNext;
      rxIdReg     <= rxIdNext;
      g1UsedReg   <= g1UsedNext;
      g2UsedReg   <= g2UsedNext;
      g3UsedReg   <= g3UsedNext;
      statusReg   <= statusNext;
      maskReg     <= maskNext;
    end
  end

  // Read data and receive verdicts, valid one cycle after their cause.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      rdataReg     <= '0;
      rxAcceptReg  <= 1'b0;
      rxDiscardReg <= 1'b0;
      rxNoDataReg  <= 1'b0;
    end else begin
      rdataReg     <= regRd ? readMux : 32'h0000_0000;
      rxAcceptReg  <= rxMatch && !rxTooLong;
      rxDiscardReg <= rxTooLong;
      rxNoDataReg  <= rxEmpty;
    end
  end

  assign regRdata     = rdataReg;
  assign rxAccept     = rxAcceptReg;
  assign rxDiscard    = rxDiscardReg;
  assign rxNoData     = rxNoDataReg;
  assign txIdentifier = txIdReg;
  assign irq          = |(statusReg & maskReg);

  ////////////////////////////////////////////////////////////////////////////
  // Assertions and cover points.
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  sel_split_a: assert property (applyGood && !applyExpl |=> selReg == $past(regWdata[15:8]))
    else $error("Selector not latched from write data.");
  g1_alloc_a: assert property (stateReg == CFG_TX && prodNib == SEL_G1 && g1Free[4]
    |=> txIdReg[10] == 1'b0 && txIdReg[5:0] == nodeReg && g1UsedReg[txIdReg[9:6]])
    else $error("Group 1 identifier badly formed.");
  g3_alloc_a: assert property (stateReg == CFG_TX && prodNib == SEL_G3 && g3Free[4]
    |=> txIdReg[10:9] == 2'b11 && txIdReg[5:0] == nodeReg && txIdReg[8:6] != 3'h7)
    else $error("Group 3 identifier badly formed.");
  g2_src_a: assert property (stateReg == CFG_TX && prodNib == SEL_G2_SRC && g2Free[4]
    |=> txIdReg[10:9] == 2'b10 && txIdReg[8:3] == nodeReg)
    else $error("Group 2 source identifier badly formed.");
  g2_dst_a: assert property (stateReg == CFG_RX && consNib == SEL_G2_DST && g2Free[4]
    |=> rxIdReg[10:9] == 2'b10 && rxIdReg[8:3] == nodeReg && stateReg == CFG_IDLE)
    else $error("Group 2 destination identifier badly formed.");
  reserved_sel_a: assert property (applyBad |=> stateReg == CFG_IDLE && statusReg[ST_INVALID]
    && selReg == $past(selReg) && txIdReg == $past(txIdReg))
    else $error("Reserved selector was not rejected.");
  tx_range_a: assert property (txIdReg <= ID_MAX || txIdReg == ID_DEFAULT)
    else $error("Transmit identifier out of range.");
  tx_limit_a: assert property (txGrant |-> txLen <= txLimEff && txIdReg != ID_DEFAULT)
    else $error("Grant beyond transmit limit.");
  expl_size_a: assert property (explicitMode && !fragTxOk && !fragRxOk
    |-> txLimEff == SIZE_NOFRAG && rxLimEff == SIZE_NOFRAG)
    else $error("Explicit limit not seven.");
  io_frag_a: assert property (!explicitMode && txLimCfgReg > SIZE_SINGLE |-> txFragment)
    else $error("Large I/O limit without fragmentation.");
  rx_discard_a: assert property (rxTooLong |=> rxDiscard && !rxAccept && statusReg[ST_DISCARD])
    else $error("Long message not discarded.");
  no_data_a: assert property (rxEmpty |=> rxNoData ##0 statusReg[ST_NODATA])
    else $error("No-data event missing.");
  io_default_a: assert property (applyGood && !applyExpl && regWdata[15:12] == SEL_DEFAULT
    |=> (txIdReg == ID_DEFAULT) [*2])
    else $error("Consumer-only transmit identifier not default.");

  // Limits, identifier guard, receive default and allocation from an empty pool.
  tx_block_a: assert property (txReq && txLen > txLimEff
    |-> txBlock && !txGrant)
    else $error("Oversized request not blocked.");
  rx_accept_a: assert property (rxMatch && rxMsgLen <= rxLimEff
    |=> rxAccept && !rxDiscard)
    else $error("Message within limit not accepted.");
  txid_guard_a: assert property (regWr && regAddr == TXID_OFS && !txIdWrOk
    && stateReg == CFG_IDLE |=> txIdReg == $past(txIdReg))
    else $error("Reserved transmit identifier stored.");
  expl_tx_open_a: assert property (explicitMode && fragTxOk && txNoLimit
    |-> txLimEff == SIZE_NOLIMIT)
    else $error("Explicit transmit limit not open.");
  expl_rx_open_a: assert property (explicitMode && fragRxOk && rxNoLimit
    |-> rxLimEff == SIZE_NOLIMIT)
    else $error("Explicit receive limit not open.");
  io_rx_default_a: assert property (applyGood && !applyExpl && regWdata[11:8] == SEL_DEFAULT
    |=> rxIdReg == ID_DEFAULT)
    else $error("Producer-only receive identifier not default.");
  pool_empty_a: assert property (stateReg == CFG_TX && prodNib == SEL_G3 && !g3Free[4] && !regWr
    |=> txIdReg == $past(txIdReg) && statusReg[ST_POOL])
    else $error("Empty pool still allocated.");

  alloc_c:   cover property (stateReg == CFG_TX && prodNib == SEL_G1 ##1 stateReg == CFG_RX);
  invalid_c: cover property (applyBad);
  discard_c: cover property (rxDiscard);
  nodata_c:  cover property (rxNoData ##1 irq);
  pool_c:    cover property (eventSet[ST_POOL]);

endmodule
`default_nettype wire

// File: far_node_model.sv
/*
  Behavioural model of the other nodes on the shared bus: it presents one
  received frame per request to the endpoint's receive port.
  Assumes it runs on the endpoint's clock and is commanded by the bench.
*/
`timescale 1ns/100ps
`default_nettype none
module far_node_model (
  input  wire logic        mclk,
  input  wire logic        rst_n,
  input  wire logic        sendStb,
  input  wire logic [10:0] sendId,
  input  wire logic [11:0] sendLen,
  output logic             rxMsgValid,
  output logic      [10:0] rxMsgId,
  output logic      [11:0] rxMsgLen
);
  // A frame stands one cycle; between frames the fields toggle so stale values never pass as a frame.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      rxMsgValid <= 1'b0;
      rxMsgId    <= 11'h000;
      rxMsgLen   <= 12'h000;
    end else begin
      rxMsgValid <= sendStb;
      rxMsgId    <= sendStb ? sendId : ~rxMsgId;  // Producer-made identifier on the wire.
      rxMsgLen   <= sendStb ? sendLen : ~rxMsgLen;
    end
  end
endmodule
`default_nettype wire

// File: test_connection_id_and_size_config.sv
/*
  Self-checking bench for the connection identifier and size configuration.
  Assumes the register map and apply timing of the design package.
*/
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin cmpCount++; if ((a) !== (b)) begin failCount++; $display("wrong value at %0t: got %h expected %h", $time, (a), (b)); end end
module test_connection_id_and_size_config;
  import conn_cfg_pkg::*;
  logic        mclk, rst_n, regWr, regRd, txReq, sendStb;
  logic [7:0]  regAddr;
  logic [31:0] regWdata, regRdata, rd;
  logic [11:0] txLen, sendLen, rxMsgLen;
  logic [10:0] sendId, rxMsgId;
  logic [15:0] txIdentifier;
  logic        irq, txGrant, txBlock, txFragment, rxMsgValid, rxAccept, rxDiscard, rxNoData;
  int          failCount, cmpCount, cycles;
  localparam logic [5:0] NODE = 6'h05;
  connection_id_and_size_config i_dut (.mclk(mclk), .rst_n(rst_n), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .irq(irq), .txReq(txReq), .txLen(txLen),
    .txGrant(txGrant), .txBlock(txBlock), .txFragment(txFragment), .txIdentifier(txIdentifier),
    .rxMsgValid(rxMsgValid), .rxMsgId(rxMsgId), .rxMsgLen(rxMsgLen), .rxAccept(rxAccept),
    .rxDiscard(rxDiscard), .rxNoData(rxNoData));
  far_node_model i_far (.mclk(mclk), .rst_n(rst_n), .sendStb(sendStb), .sendId(sendId), .sendLen(sendLen),
    .rxMsgValid(rxMsgValid), .rxMsgId(rxMsgId), .rxMsgLen(rxMsgLen));
  ////////////////////////////////////////////////////////////////////////////////
  // Clock and a hang guard that ends the run as a failure.
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 5000) begin
      failCount++;
      printVerdict();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  // Bus cycles: one-cycle strobes, read data taken in the cycle after the read.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk) begin regWr <= 1'b1; regAddr <= a; regWdata <= d; end
    @(posedge mclk) regWr <= 1'b0;
  endtask
  task automatic rdReg(input logic [7:0] a, output logic [31:0] d);
    @(posedge mclk) begin regRd <= 1'b1; regAddr <= a; end
    @(posedge mclk) regRd <= 1'b0;
    #1 d = regRdata;
  endtask
  // Applies a selector and waits four cycles; the result has settled two cycles after the write.
  task automatic applySel(input logic [7:0] sel, input logic expl);
    wr(CTRL_OFS, {16'h0000, sel, 2'b00, 1'b1, 4'h0, expl});
    repeat (4) @(posedge mclk);
    #1;
  endtask
  // Presents one frame through the far-node model and checks the three pulses.
  task automatic frame(input logic [10:0] id, input logic [11:0] len, input logic [2:0] exp);
    @(posedge mclk) begin sendStb <= 1'b1; sendId <= id; sendLen <= len; end
    @(posedge mclk) sendStb <= 1'b0;
    @(posedge mclk) #1;
    `CHK({rxAccept, rxDiscard, rxNoData}, exp)
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Scenarios.
  task automatic resetValues();
    rdReg(CTRL_OFS, rd); `CHK(rd, 32'h0000FF00)
    rdReg(TXID_OFS, rd); `CHK(rd, 32'h0000FFFF)
    rdReg(SIZE_OFS, rd); `CHK(rd, 32'h00000000)
    rdReg(8'h30, rd); `CHK(rd, 32'h00000000)
    `CHK(txIdentifier, ID_DEFAULT)
  endtask
  task automatic groupProduce();
    wr(NODE_OFS, {26'h0, NODE});
    wr(MASK_OFS, 32'h00000001);
    applySel(8'h0F, 1'b0);
    `CHK(txIdentifier, {5'h00, 4'h0, NODE})
    `CHK(irq, 1'b1)
    rdReg(STAT_OFS, rd); `CHK(rd, 32'h00000001)
    `CHK(irq, 1'b0)
    rdReg(RXID_OFS, rd); `CHK(rd, 32'h0000FFFF)
    applySel(8'h0F, 1'b0);
    `CHK(txIdentifier, {5'h00, 4'h1, NODE})
  endtask
  task automatic transmitLimit();
    wr(TXLIM_OFS, 32'h00000009);
    rdReg(SIZE_OFS, rd); `CHK(rd, 32'h00010009)
    `CHK(txFragment, 1'b1)
    rdReg(STAT_OFS, rd);
    @(posedge mclk) begin txReq <= 1'b1; txLen <= 12'h00A; end
    #1 `CHK({txGrant, txBlock}, 2'b01)
    @(posedge mclk) txLen <= 12'h009;
    #1 `CHK({txGrant, txBlock}, 2'b10)
    @(posedge mclk) txReq <= 1'b0;
    rdReg(STAT_OFS, rd); `CHK(rd, 32'h00000020)
  endtask
  task automatic otherGroups();
    applySel(8'h3F, 1'b0);
    `CHK(txIdentifier, {5'h00, 2'b11, 3'h0, NODE})
    applySel(8'h2F, 1'b0);
    `CHK(txIdentifier, {5'h00, 2'b10, NODE, 3'h0})
    rdReg(STAT_OFS, rd);
    applySel(8'h4F, 1'b0);
    rdReg(STAT_OFS, rd); `CHK(rd, 32'h00000002)
    applySel(8'hFE, 1'b0);
    rdReg(STAT_OFS, rd); `CHK(rd, 32'h00000002)
    `CHK(txIdentifier, {5'h00, 2'b10, NODE, 3'h0})
  endtask
  task automatic consumeAndReceive();
    applySel(8'hF1, 1'b0);
    `CHK(txIdentifier, ID_DEFAULT)
    rdReg(RXID_OFS, rd); `CHK(rd, {21'h0, 2'b10, NODE, 3'h1})
    wr(TXID_OFS, rd);
    #1 `CHK(txIdentifier, {5'h00, 2'b10, NODE, 3'h1})
    wr(TXID_OFS, 32'h000007F1);
    #1 `CHK(txIdentifier, {5'h00, 2'b10, NODE, 3'h1})
    wr(RXLIM_OFS, 32'h00000008);
    frame({2'b10, NODE, 3'h1}, 12'h009, 3'b010);
    frame({2'b10, NODE, 3'h1}, 12'h000, 3'b101);
    frame({2'b10, NODE, 3'h1}, 12'h008, 3'b100);
    frame({2'b10, NODE, 3'h2}, 12'h003, 3'b000);
    wr(RXID_OFS, {21'h0, 2'b11, 3'h0, NODE});
    frame({2'b11, 3'h0, NODE}, 12'h004, 3'b100);
  endtask
  task automatic explicitLimits();
    applySel(8'h00, 1'b1);
    rdReg(CTRL_OFS, rd); `CHK(rd[15:8], SEL_EXPLICIT)
    `CHK(txIdentifier, {5'h00, 2'b11, 3'h1, NODE})
    rdReg(SIZE_OFS, rd); `CHK(rd[11:0], SIZE_NOFRAG)
    frame({2'b11, 3'h0, NODE}, 12'h008, 3'b010);
    wr(CTRL_OFS, 32'h00000015);
    frame({2'b11, 3'h0, NODE}, 12'h008, 3'b100);
    wr(CTRL_OFS, 32'h0000000B);
    rdReg(SIZE_OFS, rd); `CHK(rd[11:0], SIZE_NOLIMIT)
    wr(CTRL_OFS, 32'h00000003);
    rdReg(SIZE_OFS, rd); `CHK(rd[11:0], 12'h009)
    wr(CTRL_OFS, 32'h00000000);
  endtask
  // Fills the group 3 pool, tries once more, then releases it by software.
  task automatic poolEmpty();
    repeat (5) applySel(8'h3F, 1'b0);
    `CHK(txIdentifier, {5'h00, 2'b11, 3'h6, NODE})
    rdReg(STAT_OFS, rd);
    applySel(8'h3F, 1'b0);
    rdReg(STAT_OFS, rd); `CHK(rd, 32'h00000005)
    `CHK(txIdentifier, {5'h00, 2'b11, 3'h6, NODE})
    wr(POOL_OFS, 32'h7F000000);
    applySel(8'h3F, 1'b0);
    `CHK(txIdentifier, {5'h00, 2'b11, 3'h0, NODE})
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Verdict and main sequence.
  task automatic printVerdict();
    if (failCount == 0 && cmpCount > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    failCount = 0;
    cmpCount = 0;
    cycles = 0;
    rst_n = 1'b0;
    {regWr, regRd, txReq, sendStb} = 4'h0;
    regAddr = 8'h00;
    regWdata = 32'h00000000;
    txLen = 12'h000;
    sendId = 11'h000;
    sendLen = 12'h000;
    repeat (10) @(posedge mclk);
    rst_n <= 1'b1;
    resetValues();
    groupProduce();
    transmitLimit();
    otherGroups();
    consumeAndReceive();
    explicitLimits();
    poolEmpty();
    printVerdict();
  end
endmodule
`default_nettype wire
